// >>> rtl/trbio_pkg.sv
package trbio_pkg;
  localparam int unsigned TRBIO_ADDR_W  = 15;  // A0..A14
  localparam int unsigned TRBIO_SEL_W   = 12;  // A0..A11 select field
  localparam int unsigned TRBIO_BIT_W   = 3;   // A12..A14 bit field
  localparam int unsigned TRBIO_DATA_W  = 8;   // reader character width
  localparam int unsigned TRBIO_CTL_W   = 3;   // A0..A2 transfer code
  localparam logic [2:0]  TRBIO_CTL_XFER = 3'h0; // data transfer code
  localparam logic [2:0]  TRBIO_RUN_BIT  = 3'h0; // output bit of run latch
  localparam logic [11:0] TRBIO_BASE_DEF = 12'h100; // default block
  localparam logic [2:0]  TRBIO_SYNC_INIT = 3'h0;
  typedef enum logic [1:0] {
    TRBIO_IRQ_IDLE = 2'b01,
    TRBIO_IRQ_PEND = 2'b10
  } trbio_irq_t;
endpackage : trbio_pkg

// >>> rtl/trbio_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; changes once stages two and three agree
module trbio_sync
  import trbio_pkg::*;
(
  input  wire logic i_mclk,    // system clock
  input  wire logic i_arst_n,  // async reset, active low
  input  wire logic i_async,   // pin level
  output logic      o_level    // filtered level
);
  logic [2:0] sh_r;

  // shift chain
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_r <= TRBIO_SYNC_INIT;
    end else begin
      sh_r <= {sh_r[1:0], i_async};
    end
  end

  // accept a change only when stages two and three agree
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_level <= 1'b0;
    end else if (sh_r[1] == sh_r[2]) begin
      o_level <= sh_r[2];
    end
  end
endmodule : trbio_sync

// >>> rtl/trbio_port.sv
`timescale 1ns/1ps
// tape reader port on the bit-addressed serial i/o bus
module trbio_port
  import trbio_pkg::*;
#(
  parameter logic [TRBIO_SEL_W-1:0] P_BASE = TRBIO_BASE_DEF
)(
  input  wire logic                    i_mclk,             // system clock
  input  wire logic                    i_arst_n,           // async reset
  input  wire logic [TRBIO_ADDR_W-1:0] i_addr,             // A0 is msb
  input  wire logic                    i_bitio_serial_out, // write data
  input  wire logic                    i_bitio_out_strobe, // output strobe
  input  wire logic                    i_sprocket,         // reader sprocket
  input  wire logic [TRBIO_DATA_W-1:0] i_reader_data_n,    // active low
  output logic                         o_bitio_serial_in,  // read data
  output logic                         o_bitio_serial_in_oe_n, // low: drive
  output logic                         o_reader_select_n,  // port select
  output logic                         o_reader_irq_n,     // interrupt
  output logic                         o_reader_run        // run command
);
  // read side is pure decode and mux; write side and interrupt are
  // clocked after the pin synchronisers
  logic [TRBIO_SEL_W-1:0]  sel_field;
  logic [TRBIO_BIT_W-1:0]  bit_idx;
  logic [TRBIO_CTL_W-1:0]  ctl_field;
  logic [TRBIO_DATA_W-1:0] data_pos;
  logic                    sel_hit;
  logic                    xfer_code;
  logic                    mux_bit;
  logic                    strobe_s;
  logic                    strobe_d_r;
  logic                    strobe_rise;
  logic                    write_hit;
  logic                    run_hit;
  logic                    run_nxt;
  logic                    spr_s;
  logic                    spr_d_r;
  logic                    spr_rise;
  logic                    irq_set;
  logic                    irq_clr;
  logic                    irq_n_nxt;
  trbio_irq_t              irq_st_r;
  trbio_irq_t              irq_st_nxt;

  // select field: A0-A11 sit at the top of i_addr
  function automatic logic [TRBIO_SEL_W-1:0] f_sel_field(
    input logic [TRBIO_ADDR_W-1:0] addr
  );
    return addr[TRBIO_ADDR_W-1 -: TRBIO_SEL_W];
  endfunction : f_sel_field

  // bit field: A12-A14 sit at the bottom of i_addr
  function automatic logic [TRBIO_BIT_W-1:0] f_bit_field(
    input logic [TRBIO_ADDR_W-1:0] addr
  );
    return addr[TRBIO_BIT_W-1:0];
  endfunction : f_bit_field

  // transfer code: A0-A2, the top three address bits
  function automatic logic [TRBIO_CTL_W-1:0] f_ctl_field(
    input logic [TRBIO_ADDR_W-1:0] addr
  );
    return addr[TRBIO_ADDR_W-1 -: TRBIO_CTL_W];
  endfunction : f_ctl_field

  // rising edge of a synchronised level against its history
  function automatic logic f_rise(
    input logic cur,
    input logic prev
  );
    return cur & ~prev;
  endfunction : f_rise

  // block decode against the port's base
  function automatic logic f_block_hit(
    input logic [TRBIO_ADDR_W-1:0] addr
  );
    return f_sel_field(addr) == P_BASE;
  endfunction : f_block_hit

  // pending test of the interrupt state
  function automatic logic f_pending(
    input trbio_irq_t st
  );
    return st == TRBIO_IRQ_PEND;
  endfunction : f_pending

  // address fields
  assign sel_field = f_sel_field(i_addr);
  assign bit_idx   = f_bit_field(i_addr);
  assign ctl_field = f_ctl_field(i_addr);

  // block decode over A0-A11
  assign sel_hit           = f_block_hit(i_addr);
  assign o_reader_select_n = ~sel_hit;

  // only the 000 code moves data; other codes write nothing
  assign xfer_code = (ctl_field == TRBIO_CTL_XFER);

  // per-line inversion: reader data is active low, the bus wants high
  genvar g;
  generate
    for (g = 0; g < TRBIO_DATA_W; g = g + 1) begin : g_inv
      assign data_pos[g] = ~i_reader_data_n[g];
    end
  endgenerate

  // read path is combinational so the bit settles within the second
  // clock of an input cycle; the driver is released when unselected
  assign mux_bit                = data_pos[bit_idx];
  assign o_bitio_serial_in_oe_n = ~sel_hit;
  assign o_bitio_serial_in      = sel_hit & mux_bit;

  // strobe and sprocket cross in from pins; a strobe shorter than
  // two clocks can be lost, so the bus side must widen it, and the
  // write costs about five clocks from the pin edge
  trbio_sync u_sync_strobe (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_async  (i_bitio_out_strobe),
    .o_level  (strobe_s)
  );
  trbio_sync u_sync_spr (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_async  (i_sprocket),
    .o_level  (spr_s)
  );

  // strobe history for edge detection
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= strobe_s;
    end
  end

  // sprocket history for edge detection
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      spr_d_r <= 1'b0;
    end else begin
      spr_d_r <= spr_s;
    end
  end

  // edges of the synchronised levels
  assign strobe_rise = f_rise(strobe_s, strobe_d_r);
  assign spr_rise    = f_rise(spr_s, spr_d_r);

  // address and data stand through the strobe, so sample them here
  assign write_hit = strobe_rise & sel_hit & xfer_code;
  assign run_hit   = write_hit & (bit_idx == TRBIO_RUN_BIT);

  // interrupt set and clear; a sprocket edge wins a same-cycle clear
  assign irq_set = spr_rise;
  assign irq_clr = write_hit & ~spr_rise;

  // run latch next value: only output bit 0 stores data, other
  // selected bits leave it alone but still clear the interrupt
  always_comb begin
    run_nxt = o_reader_run;
    if (run_hit) begin
      run_nxt = i_bitio_serial_out;
    end
  end

  // run latch register, cleared by reset
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reader_run <= 1'b0;
    end else begin
      o_reader_run <= run_nxt;
    end
  end

  // interrupt state: idle until a sprocket edge, pending until a
  // selected output cycle
  always_comb begin
    irq_st_nxt = irq_st_r;
    case (irq_st_r)
      TRBIO_IRQ_IDLE: begin
        if (irq_set) irq_st_nxt = TRBIO_IRQ_PEND;
      end
      TRBIO_IRQ_PEND: begin
        if (irq_clr) begin
          irq_st_nxt = TRBIO_IRQ_IDLE;
        end
      end
      default: irq_st_nxt = TRBIO_IRQ_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_st_r <= TRBIO_IRQ_IDLE;
    end else begin
      irq_st_r <= irq_st_nxt;
    end
  end

  // interrupt pin level, high whenever nothing is pending
  assign irq_n_nxt = ~f_pending(irq_st_nxt);

  // registered interrupt pin, high when idle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reader_irq_n <= 1'b1;
    end else begin
      o_reader_irq_n <= irq_n_nxt;
    end
  end
endmodule : trbio_port

// >>> test/trbio_port_properties.sv
`timescale 1ns/1ps
// pin-level checker for the tape reader port
module trbio_chk
  import trbio_pkg::*;
#(parameter logic [TRBIO_SEL_W-1:0] P_BASE = TRBIO_BASE_DEF)(
  input wire logic        i_mclk, i_arst_n, i_bitio_serial_out,
  input wire logic        i_bitio_out_strobe, i_sprocket,
  input wire logic [14:0] i_addr,
  input wire logic [7:0]  i_reader_data_n,
  input wire logic        o_bitio_serial_in, o_bitio_serial_in_oe_n,
  input wire logic        o_reader_select_n, o_reader_irq_n, o_reader_run
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // decode, driver release and bit choice
  property p_sel; o_reader_select_n == (i_addr[14:3] != P_BASE); endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_oe; o_bitio_serial_in_oe_n == o_reader_select_n; endproperty
  a_oe: assert property (p_oe) else $error("bad enable");
  property p_mux; !o_reader_select_n |->
    o_bitio_serial_in == ~i_reader_data_n[i_addr[2:0]]; endproperty
  a_mux: assert property (p_mux) else $error("bad data bit");
  // interrupt set and clear
  property p_irq; $rose(i_sprocket) |-> ##[1:6] !o_reader_irq_n; endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_clr; $rose(o_reader_irq_n) |->
    $past(i_bitio_out_strobe, 2) && !o_reader_select_n; endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  // run latch written only by a selected data write of bit zero
  property p_run; $changed(o_reader_run) |-> o_reader_run ==
    i_bitio_serial_out && i_addr[14:12] == 3'h0 &&
    i_addr[2:0] == TRBIO_RUN_BIT && !o_reader_select_n; endproperty
  a_run: assert property (p_run) else $error("bad run");
  property p_stb; $changed(o_reader_run) |->
    $past(i_bitio_out_strobe, 3); endproperty
  a_stb: assert property (p_stb) else $error("run without strobe");
  property p_rst; disable iff (1'b0) !i_arst_n |->
    !o_reader_run && o_reader_irq_n; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  cover property ($fell(o_reader_irq_n));
  cover property ($rose(o_reader_irq_n));
  cover property ($rose(o_reader_run));
endmodule : trbio_chk
bind trbio_port trbio_chk #(.P_BASE(P_BASE)) u_chk(.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .i_bitio_serial_out(i_bitio_serial_out),
  .i_bitio_out_strobe(i_bitio_out_strobe), .i_sprocket(i_sprocket),
  .i_addr(i_addr), .i_reader_data_n(i_reader_data_n),
  .o_bitio_serial_in(o_bitio_serial_in), .o_reader_run(o_reader_run),
  .o_bitio_serial_in_oe_n(o_bitio_serial_in_oe_n),
  .o_reader_select_n(o_reader_select_n), .o_reader_irq_n(o_reader_irq_n));

// >>> test/trbio_reader.sv
`timescale 1ns/1ps
// reader model: hole and character only while fed and running
module trbio_reader(
  input wire logic       i_mclk, i_run, i_feed,
  input wire logic [7:0] i_char,
  output logic           o_sprocket = 1'h0,
  output logic [7:0]     o_data_n = 8'h00
);
  // invalid data toggles every cycle
  always @(posedge i_mclk) begin
    o_sprocket <= i_run && i_feed;
    o_data_n <= (i_run && i_feed) ? ~i_char : ~o_data_n;
  end
endmodule : trbio_reader

// >>> test/trbio_port_tb.sv
`timescale 1ns/1ps
module trbio_port_tb;
  import trbio_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h1, so = 1'h0, stb = 1'h0, feed = 1'h0;
  logic [14:0] ad = 15'h0000;
  logic [7:0]  ch = 8'h00, dn;
  logic        spr, sin, oe_n, sel_n, irq_n, run;
  int          errors = 0, cmp_count = 0;
  always #5 clk = ~clk;
  trbio_port uut(.i_mclk(clk), .i_arst_n(rst_n), .i_addr(ad),
    .i_bitio_serial_out(so), .i_bitio_out_strobe(stb), .i_sprocket(spr),
    .i_reader_data_n(dn), .o_bitio_serial_in(sin), .o_reader_run(run),
    .o_bitio_serial_in_oe_n(oe_n), .o_reader_select_n(sel_n),
    .o_reader_irq_n(irq_n));
  trbio_reader u_rd(.i_mclk(clk), .i_run(run), .i_feed(feed), .i_char(ch),
    .o_sprocket(spr), .o_data_n(dn));
  task chk(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s exp %b got %b", n, e, g);
      errors++;
    end
  endtask : chk
  // address first, strobe a cycle later, held five cycles
  task wr(input logic [14:0] x, input logic d, input logic r, input logic q);
    @(posedge clk) ad <= x;
    so <= d;
    @(posedge clk) stb <= 1'h1;
    repeat (5) @(posedge clk);
    stb <= 1'h0;
    repeat (4) @(posedge clk);
    chk("run", r, run);
    chk("irq_n", q, irq_n);
    $display("write test done");
  endtask : wr
  // one character fed, interrupt seen, all eight bits read
  task t_feed(input logic [7:0] c);
    @(posedge clk) ch <= c;
    feed <= 1'h1;
    repeat (8) @(posedge clk);
    chk("irq_n", 1'h0, irq_n);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) ad <= {TRBIO_BASE_DEF, i[2:0]};
      #1 chk("data", c[i], sin);
      chk("oe_n", 1'h0, oe_n);
      chk("sel_n", 1'h0, sel_n);
    end
    feed <= 1'h0;
    $display("feed test done");
  endtask : t_feed
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    @(posedge clk) rst_n <= 1'h0;
    repeat (10) @(posedge clk);
    chk("run", 1'h0, run);
    chk("irq_n", 1'h1, irq_n);
    rst_n <= 1'h1;
    wr({TRBIO_BASE_DEF, 3'h0}, 1'h1, 1'h1, 1'h1);
    t_feed(8'ha5);
    wr({TRBIO_BASE_DEF, 3'h3}, 1'h0, 1'h1, 1'h1);
    t_feed(8'h3c);
    wr({3'h2, TRBIO_BASE_DEF[8:0], 3'h0}, 1'h0, 1'h1, 1'h0);
    chk("oe_n", 1'h1, oe_n);
    chk("sel_n", 1'h1, sel_n);
    wr({TRBIO_BASE_DEF, 3'h0}, 1'h0, 1'h0, 1'h1);
    stop_test();
  end
endmodule : trbio_port_tb
